//--- hw/coef_join.v
// joins one low word and one upper byte into a signed 24-bit coefficient
// assumes both inputs come straight from storage flip-flops
`timescale 1ns/100ps

module coef_join (
  input  wire [15:0] low_word,
  input  wire [15:0] high_pair,
  input  wire        use_upper_byte,
  output wire [23:0] coef
);

  // upper byte carries the sign; lane picked by the pair position
  assign coef = {(use_upper_byte ? high_pair[15:8] : high_pair[7:0]), low_word};

endmodule

//--- hw/coef_store.v
// calibration and configuration word store with cyclic update timer
// assumes a synchronous word port, one clock, and an async low reset
//
// Operation
// - the 3-bit interval selector in bits 14:12 picks 125 to 4000 ms for codes 1 to 6.
// - bit 15 of the configuration word picks parabolic (0) or s-shaped (1) correction.
// - bridge offset is word 03 below bits 15:8 of word 0d.
// - bridge gain is word 04 below bits 7:0 of word 0d.
// - gain drift is word 05 below bits 15:8 of word 0e.
// - offset drift is word 06 below bits 7:0 of word 0e.
// - offset drift square term is word 07 below bits 15:8 of word 0f.
// - gain drift square term is word 08 below bits 7:0 of word 0f.
// - bridge square term is word 09 below bits 15:8 of word 10.
// - temperature offset is word 0a below bits 7:0 of word 10.
// - temperature gain is word 0b below bits 15:8 of word 11, kept as stored.
// - temperature square term is word 0c below bits 7:0 of word 11.
`timescale 1ns/100ps
`include "coef_store_regs.vh"

module coef_store #(
  parameter MS_CYCLES = `MS_TIME_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire                 sys_clk,
  input  wire                 nrst,
  // word port
  input  wire                 wr_en,
  input  wire [`ADDR_W-1:0]   wr_addr,
  input  wire [`WORD_W-1:0]   wr_data,
  input  wire                 rd_en,
  input  wire [`ADDR_W-1:0]   rd_addr,
  output reg  [`WORD_W-1:0]   rd_data,
  output reg                  rd_valid,
  // configuration fields and cyclic timer
  input  wire                 cyclic_en,
  output wire [2:0]           update_interval_sel,
  output wire                 second_order_shape_sel,
  output wire [11:0]          config_low,
  output reg                  interval_valid,
  output reg  [12:0]          interval_ms,
  output reg                  cycle_wake,
  // assembled coefficients, wiring from storage
  output wire [23:0]          bridge_offset_coef,
  output wire [23:0]          bridge_gain_coef,
  output wire [23:0]          gain_drift_coef,
  output wire [23:0]          offset_drift_coef,
  output wire [23:0]          offset_drift_quadratic_coef,
  output wire [23:0]          gain_drift_quadratic_coef,
  output wire [23:0]          bridge_quadratic_coef,
  output wire [23:0]          temp_offset_coef,
  output wire [23:0]          temp_gain_coef,
  output wire [23:0]          temp_quadratic_coef
);

  // ***************************************************************
  // word map
  // ***************************************************************

  // 00-01  outside this block: read as zero, writes dropped
  // 02     cycle_and_curve_config: 15 shape, 14:12 interval, 11:0 held
  // 03     bridge_offset_coef_low
  // 04     bridge_gain_coef_low
  // 05     gain_drift_coef_low
  // 06     offset_drift_coef_low
  // 07     offset_drift_quad_low
  // 08     gain_drift_quad_low
  // 09     bridge_quad_low
  // 0a     temp_offset_coef_low
  // 0b     temp_gain_coef_low
  // 0c     temp_quad_low
  // 0d     bridge_coef_high_pair: 15:8 bridge offset, 7:0 bridge gain
  // 0e     drift_coef_high_pair: 15:8 gain drift, 7:0 offset drift
  // 0f     drift_quad_high_pair: 15:8 offset drift sq, 7:0 gain drift sq
  // 10     bridge_quad_temp_offset_high: 15:8 bridge sq, 7:0 temp offset
  // 11     temp_gain_quad_high_pair: 15:8 temp gain, 7:0 temp sq
  // 12-1f  unmapped: read as zero, writes dropped
  // words 03 to 0c are bits 15:0 of their coefficients; the upper
  // bytes in 0d to 11 carry the sign, so no write order is implied
  // a coefficient seen between its two writes is half old, half new

  // ***************************************************************
  // word port decode
  // ***************************************************************

  reg  [`NUM_WORDS-1:0]       wr_sel;
  wire [`NUM_WORDS*16-1:0]    word_bus;

  // one-hot write select by word name; words 00, 01 and 12 up select
  // nothing, so a stray write there cannot land in a neighbour
  // decoded from the full address; no subtract, so no wrap-around alias
  always @* begin
    wr_sel = 16'h0000;
    if (wr_en) begin
      case (wr_addr)
        `CYCLE_AND_CURVE_CONFIG:       wr_sel = 16'h0001;
        `BRIDGE_OFFSET_COEF_LOW:       wr_sel = 16'h0002;
        `BRIDGE_GAIN_COEF_LOW:         wr_sel = 16'h0004;
        `GAIN_DRIFT_COEF_LOW:          wr_sel = 16'h0008;
        `OFFSET_DRIFT_COEF_LOW:        wr_sel = 16'h0010;
        `OFFSET_DRIFT_QUAD_LOW:        wr_sel = 16'h0020;
        `GAIN_DRIFT_QUAD_LOW:          wr_sel = 16'h0040;
        `BRIDGE_QUAD_LOW:              wr_sel = 16'h0080;
        `TEMP_OFFSET_COEF_LOW:         wr_sel = 16'h0100;
        `TEMP_GAIN_COEF_LOW:           wr_sel = 16'h0200;
        `TEMP_QUAD_LOW:                wr_sel = 16'h0400;
        `BRIDGE_COEF_HIGH_PAIR:        wr_sel = 16'h0800;
        `DRIFT_COEF_HIGH_PAIR:         wr_sel = 16'h1000;
        `DRIFT_QUAD_HIGH_PAIR:         wr_sel = 16'h2000;
        `BRIDGE_QUAD_TEMP_OFFSET_HIGH: wr_sel = 16'h4000;
        `TEMP_GAIN_QUAD_HIGH_PAIR:     wr_sel = 16'h8000;
        default:                       wr_sel = 16'h0000;
      endcase
    end
  end

  // ***************************************************************
  // word storage
  // ***************************************************************

  genvar g;

  // one flop word per entry; writes outside the map are dropped
  // no write protect here: any strobe inside the map overwrites its word
  // reset clears every word; there is no separate erase path
  generate
    for (g = 0; g < `NUM_WORDS; g = g + 1) begin : word_slot
      reg [15:0] word_q;
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          word_q <= `WORD_RESET;
        end else if (wr_sel[g]) begin
          word_q <= wr_data;
        end
      end
      assign word_bus[g*16 +: 16] = word_q;
    end
  endgenerate

  // ***************************************************************
  // read port
  // ***************************************************************

  reg  [`WORD_W-1:0]          rd_word;

  // read mux by word name; a missing entry reads as zero, never a neighbour
  always @* begin
    rd_word = `UNMAPPED_READ;
    case (rd_addr)
      `CYCLE_AND_CURVE_CONFIG:       rd_word = word_bus[0*16 +: 16];
      `BRIDGE_OFFSET_COEF_LOW:       rd_word = word_bus[1*16 +: 16];
      `BRIDGE_GAIN_COEF_LOW:         rd_word = word_bus[2*16 +: 16];
      `GAIN_DRIFT_COEF_LOW:          rd_word = word_bus[3*16 +: 16];
      `OFFSET_DRIFT_COEF_LOW:        rd_word = word_bus[4*16 +: 16];
      `OFFSET_DRIFT_QUAD_LOW:        rd_word = word_bus[5*16 +: 16];
      `GAIN_DRIFT_QUAD_LOW:          rd_word = word_bus[6*16 +: 16];
      `BRIDGE_QUAD_LOW:              rd_word = word_bus[7*16 +: 16];
      `TEMP_OFFSET_COEF_LOW:         rd_word = word_bus[8*16 +: 16];
      `TEMP_GAIN_COEF_LOW:           rd_word = word_bus[9*16 +: 16];
      `TEMP_QUAD_LOW:                rd_word = word_bus[10*16 +: 16];
      `BRIDGE_COEF_HIGH_PAIR:        rd_word = word_bus[11*16 +: 16];
      `DRIFT_COEF_HIGH_PAIR:         rd_word = word_bus[12*16 +: 16];
      `DRIFT_QUAD_HIGH_PAIR:         rd_word = word_bus[13*16 +: 16];
      `BRIDGE_QUAD_TEMP_OFFSET_HIGH: rd_word = word_bus[14*16 +: 16];
      `TEMP_GAIN_QUAD_HIGH_PAIR:     rd_word = word_bus[15*16 +: 16];
      default:                       rd_word = `UNMAPPED_READ;
    endcase
  end

  // one cycle read latency; the answer stands until the next read
  // an unmapped word still answers, with zero and rd_valid high
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data  <= `UNMAPPED_READ;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_word;
      end
    end
  end

  // ***************************************************************
  // configuration word fields
  // ***************************************************************

  wire [15:0] cfg_word;

  // config word is slot 0 of the storage bus
  assign cfg_word = word_bus[15:0];

  // interval selector and curve shape sit in the top nibble
  assign update_interval_sel    = cfg_word[`IVL_MSB:`IVL_LSB];
  assign second_order_shape_sel = cfg_word[`SHAPE_BIT];
  // lower fields are held for other blocks, not decoded here
  assign config_low             = cfg_word[`CFG_LOW_MSB:0];

  // ***************************************************************
  // coefficient assembly
  // ***************************************************************

  wire [`NUM_COEFS*24-1:0] coef_bus;

  // coefficient i takes low word 03+i and the pair word 0d+i/2;
  // even coefficients take the upper byte of the pair
  // the join is wiring only, so a write shows on its coefficient at once
  generate
    for (g = 0; g < `NUM_COEFS; g = g + 1) begin : coef_slot
      coef_join u_join (
        .low_word       (word_bus[(g+1)*16 +: 16]),
        .high_pair      (word_bus[(11+g/2)*16 +: 16]),
        .use_upper_byte ((g % 2) == 0),
        .coef           (coef_bus[g*24 +: 24])
      );
    end
  endgenerate

  // pair word 0d: bridge offset on top, bridge gain below
  assign bridge_offset_coef          = coef_bus[0*24 +: 24];
  assign bridge_gain_coef            = coef_bus[1*24 +: 24];

  // pair word 0e: gain drift on top, offset drift below
  assign gain_drift_coef             = coef_bus[2*24 +: 24];
  assign offset_drift_coef           = coef_bus[3*24 +: 24];

  // pair word 0f: offset drift square term on top, gain drift square term below
  assign offset_drift_quadratic_coef = coef_bus[4*24 +: 24];
  assign gain_drift_quadratic_coef   = coef_bus[5*24 +: 24];

  // pair word 10: bridge square term on top, temperature offset below
  assign bridge_quadratic_coef       = coef_bus[6*24 +: 24];
  assign temp_offset_coef            = coef_bus[7*24 +: 24];

  // pair word 11: temperature gain on top, temperature square term below
  // magnitude quantity; passed on as stored, the consumer owns the sign
  assign temp_gain_coef              = coef_bus[8*24 +: 24];
  assign temp_quadratic_coef         = coef_bus[9*24 +: 24];

  // ***************************************************************
  // interval decode
  // ***************************************************************

  reg [12:0] ivl_ms_d;
  reg        ivl_valid_d;

  // unassigned codes give no interval rather than a nearby one
  always @* begin
    ivl_valid_d = 1'b1;
    case (update_interval_sel)
      `IVL_CODE_125:  ivl_ms_d = `IVL_125_MS;
      `IVL_CODE_250:  ivl_ms_d = `IVL_250_MS;
      `IVL_CODE_500:  ivl_ms_d = `IVL_500_MS;
      `IVL_CODE_1000: ivl_ms_d = `IVL_1000_MS;
      `IVL_CODE_2000: ivl_ms_d = `IVL_2000_MS;
      `IVL_CODE_4000: ivl_ms_d = `IVL_4000_MS;
      // both unassigned codes spelled out so the fallback reads plainly
      3'h0: begin
        ivl_ms_d    = `IVL_NONE_MS;
        ivl_valid_d = 1'b0;
      end
      3'h7: begin
        ivl_ms_d    = `IVL_NONE_MS;
        ivl_valid_d = 1'b0;
      end
      default: begin
        ivl_ms_d    = `IVL_NONE_MS;
        ivl_valid_d = 1'b0;
      end
    endcase
  end

  // registered so the timer sees a clean value one cycle after a write
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      interval_ms    <= `IVL_NONE_MS;
      interval_valid <= 1'b0;
    end else begin
      interval_ms    <= ivl_ms_d;
      interval_valid <= ivl_valid_d;
    end
  end

  // ***************************************************************
  // cyclic update timer
  // ***************************************************************

  // the prescaler is 16 bits wide, so MS_CYCLES must stay at 65536 or below
  localparam [31:0] MS_SPAN = MS_CYCLES - 1;
  localparam [15:0] MS_LAST = MS_SPAN[15:0];

  reg  [15:0] prescale_q;
  reg  [15:0] prescale_d;
  reg  [12:0] ms_cnt_q;
  reg  [12:0] ms_cnt_d;
  reg  [12:0] ivl_prev_q;
  reg         wake_d;
  wire        run;
  wire        restart;
  wire        ms_tick;

  // timer runs only with a valid interval; a new interval restarts it
  // so a shorter interval never has to wait out a longer one
  assign run     = cyclic_en && interval_valid;
  assign restart = (ivl_prev_q != interval_ms);
  assign ms_tick = (prescale_q == MS_LAST);

  // a word 02 write shows on the selector at once, on interval_ms one edge
  // later, and, if interval_ms changed, clears both counters the edge after that; from there a wake
  // comes every interval_ms * MS_CYCLES edges while enabled
  // limits: cyclic_en low holds both counters at zero, so enabling again
  // starts a full interval instead of finishing the old one; the wake is
  // one cycle wide and must not be gated by the consumer
  // millisecond base and interval count; wake fires at interval end
  always @* begin
    prescale_d = prescale_q;
    ms_cnt_d   = ms_cnt_q;
    wake_d     = 1'b0;
    if (!run || restart) begin
      prescale_d = 16'h0000;
      ms_cnt_d   = 13'h0000;
    end else if (ms_tick) begin
      prescale_d = 16'h0000;
      if (ms_cnt_q == interval_ms - 13'h0001) begin
        ms_cnt_d = 13'h0000;
        wake_d   = 1'b1;
      end else begin
        ms_cnt_d = ms_cnt_q + 13'h0001;
      end
    end else begin
      prescale_d = prescale_q + 16'h0001;
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prescale_q <= 16'h0000;
      ms_cnt_q   <= 13'h0000;
      ivl_prev_q <= `IVL_NONE_MS;
      cycle_wake <= 1'b0;
    end else begin
      prescale_q <= prescale_d;
      ms_cnt_q   <= ms_cnt_d;
      ivl_prev_q <= interval_ms;
      cycle_wake <= wake_d;
    end
  end

endmodule

//--- hw/coef_store_regs.vh
// register word map, field positions, reset values and timing counts
// assumes inclusion by the coefficient store and its bench only
`ifndef COEF_STORE_REGS_VH
`define COEF_STORE_REGS_VH

// word addresses on the word port
`define ADDR_W                  5
`define WORD_W                  16
`define CYCLE_AND_CURVE_CONFIG  5'h02
`define BRIDGE_OFFSET_COEF_LOW  5'h03
`define BRIDGE_GAIN_COEF_LOW    5'h04
`define GAIN_DRIFT_COEF_LOW     5'h05
`define OFFSET_DRIFT_COEF_LOW   5'h06
`define OFFSET_DRIFT_QUAD_LOW   5'h07
`define GAIN_DRIFT_QUAD_LOW     5'h08
`define BRIDGE_QUAD_LOW         5'h09
`define TEMP_OFFSET_COEF_LOW    5'h0a
`define TEMP_GAIN_COEF_LOW      5'h0b
`define TEMP_QUAD_LOW           5'h0c
`define BRIDGE_COEF_HIGH_PAIR   5'h0d
`define DRIFT_COEF_HIGH_PAIR    5'h0e
`define DRIFT_QUAD_HIGH_PAIR    5'h0f
`define BRIDGE_QUAD_TEMP_OFFSET_HIGH 5'h10
`define TEMP_GAIN_QUAD_HIGH_PAIR 5'h11
`define FIRST_WORD              5'h02
`define LAST_WORD               5'h11
`define NUM_WORDS               16
`define NUM_COEFS               10

// configuration word fields
`define SHAPE_BIT               15
`define IVL_MSB                 14
`define IVL_LSB                 12
`define CFG_LOW_MSB             11

// reset values
`define WORD_RESET              16'h0000
`define UNMAPPED_READ           16'h0000

// update interval codes
`define IVL_CODE_125            3'h1
`define IVL_CODE_250            3'h2
`define IVL_CODE_500            3'h3
`define IVL_CODE_1000           3'h4
`define IVL_CODE_2000           3'h5
`define IVL_CODE_4000           3'h6

// update intervals in milliseconds
`define IVL_125_MS              13'h007d
`define IVL_250_MS              13'h00fa
`define IVL_500_MS              13'h01f4
`define IVL_1000_MS             13'h03e8
`define IVL_2000_MS             13'h07d0
`define IVL_4000_MS             13'h0fa0
`define IVL_NONE_MS             13'h0000

// timing base
`define CLK_PERIOD_NS           20
`define MS_TIME_NS              1000000

`endif

//--- test/coef_store_sva.sv
// assertions on the coefficient store ports
// assumes a bind onto coef_store, one clock and an async low reset
`timescale 1ns/100ps
module coef_store_sva #(
  parameter MS_CYCLES = 50000
) (
  input wire        sys_clk,
  input wire        nrst,
  input wire        wr_en,
  input wire [4:0]  wr_addr,
  input wire [15:0] wr_data,
  input wire        rd_en,
  input wire [4:0]  rd_addr,
  input wire [15:0] rd_data,
  input wire        rd_valid,
  input wire        cyclic_en,
  input wire [2:0]  update_interval_sel,
  input wire        second_order_shape_sel,
  input wire [11:0] config_low,
  input wire        interval_valid,
  input wire [12:0] interval_ms,
  input wire        cycle_wake,
  input wire [23:0] bridge_offset_coef,
  input wire [23:0] bridge_gain_coef,
  input wire [23:0] gain_drift_coef,
  input wire [23:0] offset_drift_coef,
  input wire [23:0] offset_drift_quadratic_coef,
  input wire [23:0] gain_drift_quadratic_coef,
  input wire [23:0] bridge_quadratic_coef,
  input wire [23:0] temp_offset_coef,
  input wire [23:0] temp_gain_coef,
  input wire [23:0] temp_quadratic_coef
);
  // ********************
  // helpers and checks
  // ********************
  // coefficients in word order, lowest address at the bottom
  wire [239:0] cf = {temp_quadratic_coef, temp_gain_coef, temp_offset_coef,
    bridge_quadratic_coef, gain_drift_quadratic_coef, offset_drift_quadratic_coef,
    offset_drift_coef, gain_drift_coef, bridge_gain_coef, bridge_offset_coef};
  // zero marks the unassigned codes
  wire [103:0] ms_tbl = {13'h0000, 13'h0fa0, 13'h07d0, 13'h03e8, 13'h01f4,
    13'h00fa, 13'h007d, 13'h0000};
  wire [12:0]  exp_ms = ms_tbl[13*update_interval_sel +: 13];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_req; rd_en; endsequence
  sequence s_unmap_rd; rd_en && (rd_addr < 5'h02 || rd_addr > 5'h11); endsequence
  property p_ivl; $stable(update_interval_sel) |-> interval_ms == exp_ms; endproperty
  property p_valid; $stable(update_interval_sel) |-> interval_valid == (exp_ms != 0);
  endproperty
  property p_cfg; wr_en && wr_addr == 5'h02 |=>
    {second_order_shape_sel, update_interval_sel, config_low} == $past(wr_data);
  endproperty
  property p_low; wr_en && wr_addr >= 5'h03 && wr_addr <= 5'h0c |=>
    cf[24*($past(wr_addr)-5'h03) +: 16] == $past(wr_data); endproperty
  property p_high; wr_en && wr_addr >= 5'h0d && wr_addr <= 5'h11 |=>
    {cf[48*($past(wr_addr)-5'h0d)+16 +: 8], cf[48*($past(wr_addr)-5'h0d)+40 +: 8]}
    == $past(wr_data); endproperty
  property p_rdv; s_rd_req ##1 !rd_en |-> rd_valid ##1 !rd_valid; endproperty
  property p_unmap; s_unmap_rd |=> rd_valid && rd_data == 16'h0000; endproperty
  property p_wake; cycle_wake |-> $past(cyclic_en) && $past(interval_valid); endproperty
  a_ivl: assert property (p_ivl) else $error("interval length wrong");
  a_valid: assert property (p_valid) else $error("interval valid wrong");
  a_cfg: assert property (p_cfg) else $error("config fields wrong");
  a_low: assert property (p_low)
    else $error("coefficient low word wrong");
  a_high: assert property (p_high)
    else $error("coefficient upper byte wrong");
  a_rdv: assert property (p_rdv) else $error("read valid not one cycle");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_wake: assert property (p_wake) else $error("wake while stopped");
endmodule
bind coef_store coef_store_sva #(.MS_CYCLES(MS_CYCLES)) coef_store_sva_inst (.*);

//--- test/testbench.sv
// self-checking bench for the coefficient store word port and timer
// assumes coef_store is compiled first; short ms count keeps runs brief
`timescale 1ns/100ps
module testbench;
  localparam MSC = 4;
  reg          sys_clk, nrst, wr_en, rd_en, cyclic_en;
  reg  [4:0]   wr_addr, rd_addr;
  reg  [15:0]  wr_data, v;
  wire [15:0]  rd_data;
  wire         rd_valid, second_order_shape_sel, interval_valid, cycle_wake;
  wire [2:0]   update_interval_sel;
  wire [11:0]  config_low;
  wire [12:0]  interval_ms;
  wire [23:0]  bridge_offset_coef, bridge_gain_coef, gain_drift_coef, offset_drift_coef;
  wire [23:0]  offset_drift_quadratic_coef, gain_drift_quadratic_coef;
  wire [23:0]  bridge_quadratic_coef, temp_offset_coef, temp_gain_coef, temp_quadratic_coef;
  wire [239:0] coefs = {temp_quadratic_coef, temp_gain_coef, temp_offset_coef,
    bridge_quadratic_coef, gain_drift_quadratic_coef, offset_drift_quadratic_coef,
    offset_drift_coef, gain_drift_coef, bridge_gain_coef, bridge_offset_coef};
  wire [103:0] ms_tbl = {13'h0000, 13'h0fa0, 13'h07d0, 13'h03e8, 13'h01f4,
    13'h00fa, 13'h007d, 13'h0000};
  int          n_fail = 0;
  int          checks_done = 0;
  int          i, j, k, n;

  coef_store #(.MS_CYCLES(MSC)) coef_store_inst (.*);

  // ********************
  // access tasks
  // ********************
  // distinct word per address, sign bit set
  function [15:0] f_w(input int a);
    f_w = 16'h9080 ^ (a[15:0] * 16'h0111);
  endfunction
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one port cycle, strobes dropped just after the taking edge
  task op(input we, input [4:0] wa, input [15:0] wd, input re, input [4:0] ra);
    @(posedge sys_clk);
    #1;
    {wr_en, wr_addr, wr_data, rd_en, rd_addr} = {we, wa, wd, re, ra};
    @(posedge sys_clk);
    #1;
    {wr_en, rd_en} = 2'b00;
  endtask
  task rd(input int a, input [15:0] exp);
    op(1'b0, 5'h00, 16'h0000, 1'b1, a[4:0]);
    chk("rd_valid", rd_valid, 1'b1);
    chk("rd_data", rd_data, exp);
  endtask
  // bounded wait; k ends as cycles since the last wake
  task wait_wake;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (cycle_wake !== 1'b1 && k < 17000);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ********************
  // clock, watchdog and tests
  // ********************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // longest path is two of every interval, about 66000 cycles
  initial begin
    repeat (95000) @(posedge sys_clk);
    n_fail++;
    end_sim;
  end
  initial begin
    {nrst, wr_en, rd_en, cyclic_en} = 4'h0;
    {wr_addr, rd_addr, wr_data, v} = 42'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    for (i = 0; i < 20; i++) rd(i, 16'h0000);
    $display("test reset values done");
    for (i = 1; i < 19; i++) op(1'b1, i[4:0], f_w(i), 1'b0, 5'h00);
    for (i = 0; i < 20; i++) rd(i, (i > 1 && i < 18) ? f_w(i) : 16'h0000);
    for (i = 0; i < 5; i++) begin
      v = f_w(13 + i);
      chk("ca", coefs[48*i +: 24], {v[15:8], f_w(3+2*i)});
      chk("cb", coefs[48*i+24 +: 24], {v[7:0], f_w(4+2*i)});
    end
    // write and read of one word in one cycle returns the old word
    op(1'b1, 5'h03, 16'h2222, 1'b1, 5'h03);
    chk("old", rd_data, f_w(3));
    rd(3, 16'h2222);
    $display("test word map done");
    for (i = 0; i < 16; i++) begin
      v = {i[3:0], 12'h5a5};
      op(1'b1, 5'h02, v, 1'b0, 5'h00);
      @(posedge sys_clk);
      #1;
      chk("shape", second_order_shape_sel, v[15]);
      chk("sel", update_interval_sel, v[14:12]);
      chk("low", config_low, v[11:0]);
      chk("ms", interval_ms, ms_tbl[13*v[14:12] +: 13]);
      chk("valid", interval_valid, ms_tbl[13*v[14:12] +: 13] != 0);
    end
    $display("test config fields done");
    cyclic_en = 1'b1;
    for (i = 1; i < 7; i++) begin
      op(1'b1, 5'h02, {1'b0, i[2:0], 12'h000}, 1'b0, 5'h00);
      wait_wake;
      wait_wake;
      chk("period", k, ms_tbl[13*i +: 13] * MSC);
    end
    // unassigned code, then a valid code with the timer disabled
    for (j = 0; j < 2; j++) begin
      cyclic_en = (j == 0);
      op(1'b1, 5'h02, j ? 16'h1000 : 16'h7000, 1'b0, 5'h00);
      n = 0;
      repeat (1200) begin
        @(posedge sys_clk);
        #1;
        if (cycle_wake === 1'b1) n++;
      end
      chk("no_wake", n, 0);
    end
    $display("test cyclic timer done");
    end_sim;
  end
endmodule
